//--- design/dtsm_dma.sv
// Four-channel interrupt-triggered engine with single and single-step transfer modes
//
// Operation
// [RQ1] Each channel has a six-bit trigger_source_select choosing its starting interrupt source.
// [RQ2] Software writes only assigned source codes; reserved codes give undefined behaviour.
// [RQ3] Selected source starts a transfer regardless of any CPU interrupt mask.
// [RQ4] Software should mask trigger interrupts so the CPU does not service them.
// [RQ5] Single mode releases the bus after every unit moved.
// [RQ6] Single mode: while a request remains, one more unit per round until count ends.
// [RQ7] After release, a pending higher priority channel wins the next transfer.
// [RQ8] Lower request arising within one clock of a unit's end is served next.
// [RQ9] Two simultaneous steady single-mode requests alternate, one unit each.
// [RQ10] Three or more: only the two highest alternate; the rest wait.
// [RQ11] Single-step mode releases the bus per unit; each new request gives one unit.
// [RQ12] Single-step: after release the higher priority request is always granted first; the code still grants a lower request fresh at the unit end first.
// [RQ13] Fixed priority: channel 0 highest, channel 3 lowest.
`timescale 1ns/1ps
`include "dtsm_map.svh"
module dtsm_dma #(
    parameter int NCH = 4,
    parameter int DATA_W = 16,
    parameter int CNT_W = 16,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Interrupt sources from pins and peripherals, indexed by source code
    input wire logic [63:0] i_irq_src,
    // Channel configuration from the control block
    input wire logic [NCH*`DTSM_SEL_W-1:0] i_trigger_source_select,
    input wire logic [NCH-1:0] i_step_mode,
    input wire logic [NCH-1:0] i_cnt_load,
    input wire logic [CNT_W-1:0] i_cnt_value,
    // System bus shared with the CPU
    output logic o_bus_req,
    output logic [1:0] o_bus_ch,
    input wire logic i_bus_done,
    input wire logic [DATA_W-1:0] i_bus_rdata,
    // Data stream out of the buffer
    output logic o_data_valid,
    output logic [DATA_W-1:0] o_data,
    input wire logic i_data_ready,
    // Terminal count pulses, also the channel done interrupts, and per-channel count-not-zero flags
    output logic [NCH-1:0] o_done_irq,
    output logic [NCH-1:0] o_active
);
    // Priority logic is written for exactly four channels
    if (NCH != 4 || CNT_W < 1 || DATA_W < 1) begin : g_bad_param
        $error("dtsm_dma: NCH must be 4");
    end

    // CPU slot length in cycles, also the width of the slot shifter
    localparam int SLOT_W = `DTSM_CPU_SLOT_CYC;

    typedef struct packed {
        dtsm_pkg::dtsm_state_t st;
        logic [63:0] sync1;
        logic [63:0] sync2;
        logic [NCH-1:0] lvl_prev;
        logic [NCH-1:0] pend;
        logic [NCH-1:0] fresh;
        logic [NCH-1:0][CNT_W-1:0] cnt;
        logic [1:0] cur;
        logic [1:0] last;
        logic last_single;
        logic [NCH-1:0] done;
        logic [`DTSM_CPU_SLOT_CYC-1:0] slot;
    } dtsm_st_t;

    dtsm_st_t s_q;
    dtsm_st_t s_d;
    logic [63:0] src_all;
    logic [NCH-1:0] lvl;
    logic [NCH-1:0] rise;
    logic [NCH-1:0] req;
    logic [NCH-1:0] act;
    logic [2:0] p1;
    logic [2:0] p2;
    logic [2:0] pf;
    logic [1:0] pick;
    logic fifo_ready;
    logic push;

    // Lowest index wins: {found, index}
    function automatic logic [2:0] dtsm_first(input logic [3:0] v);
        logic [2:0] r;
        r = 3'h0;
        if (v[0]) begin
            r = 3'h4;
        end else if (v[1]) begin
            r = 3'h5;
        end else if (v[2]) begin
            r = 3'h6;
        end else if (v[3]) begin
            r = 3'h7;
        end
        return r;
    endfunction : dtsm_first

    // Raw sources plus our own done pulses; no mask is applied here [RQ3]
    always_comb begin
        src_all = s_q.sync2;
        src_all[`DTSM_SRC_DONE0 +: NCH] = s_q.sync2[`DTSM_SRC_DONE0 +: NCH] | s_q.done;
    end

    // Per-channel trigger pick, edge and request terms
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [`DTSM_SEL_W-1:0] sel;
        assign sel = i_trigger_source_select[c*`DTSM_SEL_W + `DTSM_SEL_LSB +: `DTSM_SEL_W]; // [RQ1]
        assign lvl[c] = src_all[sel]; // [RQ1]
        assign rise[c] = lvl[c] && !s_q.lvl_prev[c];
        assign act[c] = (s_q.cnt[c] != '0);
        // Single mode keeps asking while the source stays high; single-step needs a new edge
        assign req[c] = act[c] && (s_q.pend[c] || (!i_step_mode[c] && lvl[c])); // [RQ6] [RQ11]
    end

    // Arbitration: fixed order, fresh late requests, top-two alternation
    always_comb begin
        p1 = dtsm_first(req); // [RQ13]
        p2 = dtsm_first(req & ~(4'h1 << p1[1:0]));
        // The channel just served never counts as a late newcomer
        pf = dtsm_first(req & s_q.fresh & ~(4'h1 << s_q.last));
        if (pf[2]) begin
            pick = pf[1:0]; // [RQ8]
        end else if (s_q.last_single && p1[1:0] == s_q.last && p2[2] && !i_step_mode[p1[1:0]]
                     && !i_step_mode[p2[1:0]]) begin
            pick = p2[1:0]; // [RQ9] [RQ10]
        end else begin
            pick = p1[1:0]; // [RQ7] [RQ12]
        end
    end

    assign push = (s_q.st == dtsm_pkg::DTSM_XFER) && i_bus_done;

    // Next state
    always_comb begin
        s_d = s_q;
        // Two flops on every source; only the second is read
        s_d.sync1 = i_irq_src;
        s_d.sync2 = s_q.sync1;
        s_d.lvl_prev = lvl;
        s_d.done = '0;
        s_d.slot = '0;
        // Fresh flags live only for the unit end and the CPU slot after it
        if (s_q.st == dtsm_pkg::DTSM_IDLE) begin
            s_d.fresh = '0;
        end
        case (s_q.st)
            dtsm_pkg::DTSM_IDLE: begin
                // Hold off while the buffer is full so the stream stalls the engine
                if ((req != '0) && fifo_ready) begin
                    s_d.st = dtsm_pkg::DTSM_XFER;
                    s_d.cur = pick;
                    s_d.pend[pick] = 1'b0;
                end else if (req == '0) begin
                    // A quiet engine forgets its pair, so a new burst starts from the top
                    s_d.last_single = 1'b0; // [RQ9]
                end
            end
            dtsm_pkg::DTSM_XFER: begin
                if (i_bus_done) begin
                    s_d.cnt[s_q.cur] = s_q.cnt[s_q.cur] - 1'b1; // [RQ6] [RQ11]
                    if (s_q.cnt[s_q.cur] == CNT_W'(1)) begin
                        s_d.done[s_q.cur] = 1'b1;
                    end
                    s_d.last = s_q.cur;
                    s_d.last_single = !i_step_mode[s_q.cur];
                    s_d.fresh = rise; // [RQ8]
                    s_d.st = dtsm_pkg::DTSM_REL; // [RQ5] [RQ11]
                end
            end
            dtsm_pkg::DTSM_REL: begin
                // Bus is the CPU's for this slot
                s_d.fresh = s_q.fresh | rise; // [RQ8]
                // Ones fill the shifter; the slot ends once the top bit is reached
                s_d.slot = SLOT_W'({s_q.slot, 1'b1});
                if (s_d.slot[SLOT_W-1]) begin
                    s_d.st = dtsm_pkg::DTSM_IDLE;
                end
            end
            default: begin
                s_d.st = dtsm_pkg::DTSM_IDLE;
            end
        endcase
        // New edges set pending, overriding a clear in the same cycle
        s_d.pend = s_d.pend | (rise & act);
        // Loading a count starts the channel afresh
        for (int c = 0; c < NCH; c++) begin
            if (i_cnt_load[c]) begin
                s_d.cnt[c] = i_cnt_value;
                s_d.pend[c] = 1'b0;
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.st <= dtsm_pkg::DTSM_IDLE;
            s_q.cur <= `DTSM_CH_RST;
            s_q.last <= `DTSM_CH_RST;
            for (int c = 0; c < NCH; c++) begin
                s_q.cnt[c] <= `DTSM_CNT_RST;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // Bus held only through one unit
    assign o_bus_req = (s_q.st == dtsm_pkg::DTSM_XFER); // [RQ5]
    assign o_bus_ch = s_q.cur;
    assign o_done_irq = s_q.done;
    assign o_active = act;

    // Data moved by each unit lands in the buffer
    dtsm_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(push),
        .i_in_data(i_bus_rdata),
        .o_in_ready(fifo_ready),
        .o_out_valid(o_data_valid),
        .o_out_data(o_data),
        .i_out_ready(i_data_ready)
    );

endmodule : dtsm_dma

//--- design/dtsm_map.svh
// Field positions, source codes, reset values and timing counts of the trigger and transfer-mode logic
`ifndef DTSM_MAP_SVH
`define DTSM_MAP_SVH

// Trigger source select field inside each channel's control word
`define DTSM_SEL_MSB 5
`define DTSM_SEL_LSB 0
`define DTSM_SEL_W 6

// Source codes on the internal interrupt source vector
`define DTSM_SRC_PIN5 6'h06
`define DTSM_SRC_TIMER00 6'h0A
`define DTSM_SRC_DONE0 6'h22
`define DTSM_SRC_DONE3 6'h25
`define DTSM_SRC_SERIAL0_RX 6'h2C
`define DTSM_SRC_CONV0 6'h33
`define DTSM_SRC_LAST 6'h36

// Reset values
`define DTSM_CNT_RST 16'h0000
`define DTSM_CH_RST 2'h0

// CPU bus slot after each unit, in ns, and the cycle count at 100 ns per clock
`define DTSM_CLK_NS 100
`define DTSM_CPU_SLOT_NS 100
`define DTSM_CPU_SLOT_CYC ((`DTSM_CPU_SLOT_NS + `DTSM_CLK_NS - 1) / `DTSM_CLK_NS)

`endif

//--- design/dtsm_pkg.sv
// Types shared by the trigger and transfer-mode logic
package dtsm_pkg;

    // Sequencer states of the channel engine
    typedef enum logic [1:0] {
        DTSM_IDLE,
        DTSM_XFER,
        DTSM_REL
    } dtsm_state_t;

endpackage : dtsm_pkg

//--- design/dtsm_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dtsm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Depth must be a power of two so the pointers wrap freely
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
        $error("dtsm_fifo: DEPTH must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } dtsm_fifo_st_t;

    dtsm_fifo_st_t s_q;
    dtsm_fifo_st_t s_d;
    logic push;
    logic pop;

    // Honest flags straight from the occupancy count
    assign o_in_ready = (s_q.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_q.cnt != '0);
    assign o_out_data = s_q.mem[s_q.rd];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // Next state of storage and pointers
    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = i_in_data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: s_d.cnt = s_q.cnt + 1'b1;
            2'b01: s_d.cnt = s_q.cnt - 1'b1;
            default: s_d.cnt = s_q.cnt;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : dtsm_fifo

//--- bench/dtsm_dma_properties.sv
// Concurrent checks on the bus and stream ports of the DMA engine
`timescale 1ns/1ps
module dtsm_dma_properties (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Watched ports
    input wire logic i_bus_done,
    input wire logic i_data_ready,
    input wire logic o_bus_req,
    input wire logic [1:0] o_bus_ch,
    input wire logic o_data_valid,
    input wire logic [15:0] o_data,
    input wire logic [3:0] o_done_irq,
    input wire logic [3:0] o_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Bus left to the CPU slot and the idle cycle after each unit
    sequence slot_gap_s; !o_bus_req ##1 !o_bus_req; endsequence
    sequence unit_open_s; o_bus_req && !i_bus_done; endsequence
    bus_release_a: assert property (o_bus_req && i_bus_done |=> slot_gap_s) else $error("bus kept");
    req_hold_a: assert property (unit_open_s |=> o_bus_req) else $error("unit dropped early");
    ch_stable_a: assert property (o_bus_req && $past(o_bus_req) |-> $stable(o_bus_ch)) else $error("ch moved");
    active_only_a: assert property ($rose(o_bus_req) |-> o_active[o_bus_ch]) else $error("idle ch ran");
    no_count_a: assert property (o_active == 4'h0 |-> !o_bus_req) else $error("req with no count");
    // Terminal count pulse belongs to the unit just finished
    done_cause_a: assert property (|o_done_irq |-> $past(o_bus_req && i_bus_done) && o_done_irq == 4'h1 << o_bus_ch
        && (o_done_irq & o_active) == 4'h0) else $error("stray done");
    word_push_a: assert property (o_bus_req && i_bus_done |=> o_data_valid) else $error("word lost");
    data_hold_a: assert property (o_data_valid && !i_data_ready |=> o_data_valid && $stable(o_data))
        else $error("head moved");
endmodule : dtsm_dma_properties

bind dtsm_dma dtsm_dma_properties i_dtsm_dma_properties (.i_clk(i_clk), .i_rst(i_rst), .i_bus_done(i_bus_done),
    .i_data_ready(i_data_ready), .o_bus_req(o_bus_req), .o_bus_ch(o_bus_ch), .o_data_valid(o_data_valid),
    .o_data(o_data), .o_done_irq(o_done_irq), .o_active(o_active));

//--- bench/dtsm_bus_model.sv
// System bus partner that ends each unit after a random wait
`timescale 1ns/1ps
module dtsm_bus_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Unit request from the engine
    input wire logic i_req,
    input wire logic [1:0] i_ch,
    // Unit end and its data
    output logic o_done,
    output logic [15:0] o_rdata
);
    logic [13:0] seq_q;
    int wait_q;
    // Data carries channel and order; outside a unit it toggles so stale data never matches
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_done <= 1'b0;
            o_rdata <= 16'h0000;
            seq_q <= 14'h0000;
            wait_q <= 0;
        end else if (o_done || !i_req || wait_q != 0) begin
            o_done <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_req && !o_done && wait_q != 0) wait_q <= wait_q - 1;
        end else begin
            o_done <= 1'b1;
            o_rdata <= {i_ch, seq_q};
            seq_q <= seq_q + 14'h0001;
            wait_q <= $urandom_range(0, 2);
        end
    end
endmodule : dtsm_bus_model

//--- bench/testbench.sv
// Self-checking bench for trigger selection and single and single-step modes
`timescale 1ns/1ps
`include "dtsm_map.svh"
module testbench;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [63:0] i_irq_src = '0;
    logic [23:0] i_trigger_source_select = '0;
    logic [3:0] i_step_mode = '0;
    logic [3:0] i_cnt_load = '0;
    logic [15:0] i_cnt_value = '0;
    logic i_data_ready = 1'b0;
    logic hold = 1'b0;
    logic o_bus_req, i_bus_done, o_data_valid;
    logic [1:0] o_bus_ch;
    logic [15:0] i_bus_rdata, o_data;
    logic [3:0] o_done_irq, o_active;
    // Only assigned source codes are ever selected; no CPU services the sources
    logic [5:0] codes [4] = '{`DTSM_SRC_PIN5, `DTSM_SRC_TIMER00, `DTSM_SRC_SERIAL0_RX, `DTSM_SRC_CONV0};
    logic [13:0] seq_exp = 14'h0000;
    logic [1:0] got [$];
    int failures = 0;
    int samples_checked = 0;
    int units = 0;
    int dones = 0;
    int k, m, q;
    dtsm_dma i_dtsm_dma (.i_clk(i_clk), .i_rst(i_rst), .i_irq_src(i_irq_src),
        .i_trigger_source_select(i_trigger_source_select), .i_step_mode(i_step_mode), .i_cnt_load(i_cnt_load),
        .i_cnt_value(i_cnt_value), .o_bus_req(o_bus_req), .o_bus_ch(o_bus_ch), .i_bus_done(i_bus_done),
        .i_bus_rdata(i_bus_rdata), .o_data_valid(o_data_valid), .o_data(o_data), .i_data_ready(i_data_ready),
        .o_done_irq(o_done_irq), .o_active(o_active));
    dtsm_bus_model i_dtsm_bus_model (.i_clk(i_clk), .i_rst(i_rst), .i_req(o_bus_req), .i_ch(o_bus_ch),
        .o_done(i_bus_done), .o_rdata(i_bus_rdata));
    // Clock, then drain side stalling at random
    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) #1 i_data_ready <= hold ? 1'b0 : 1'($urandom_range(0, 1));
    // Log popped words, units and terminal counts; seen before the edge's own updates
    always @(posedge i_clk) begin
        if (o_data_valid === 1'b1 && i_data_ready) begin
            got.push_back(o_data[15:14]);
            check(32'(o_data[13:0]), 32'(seq_exp));
            seq_exp <= seq_exp + 14'h0001;
        end
        if (i_bus_done && o_bus_req === 1'b1) units++;
        dones += $countones(o_done_irq);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    task automatic wait_words(input int n);
        for (int i = 0; i < 4000 && got.size() < n; i++) @(posedge i_clk);
        if (got.size() < n) begin
            failures++;
            wrap_up();
        end
    endtask : wait_words
    // Order of units for steady simultaneous requests: lowest index, top two alternate
    function automatic logic [31:0] order(input logic [3:0] chs, input int cnt);
        int left [4];
        int last, n, a, b, c;
        logic [31:0] r;
        r = '0;
        last = -1;
        n = 0;
        for (c = 0; c < 4; c++) left[c] = chs[c] ? cnt : 0;
        while (left[0] + left[1] + left[2] + left[3] > 0) begin
            a = -1;
            b = -1;
            for (c = 3; c >= 0; c--) if (left[c] > 0) begin
                b = a;
                a = c;
            end
            c = (last == a && b >= 0) ? b : a;
            r[2*n +: 2] = c[1:0];
            left[c]--;
            last = c;
            n++;
        end
        return r;
    endfunction : order
    // Load counts, raise each channel's own source, compare the drained channel order
    task automatic run(input logic [3:0] chs, input logic [3:0] step, input int cnt, input logic [31:0] exp,
        input int n);
        int d0;
        d0 = dones;
        got.delete();
        @(posedge i_clk);
        #1 i_step_mode = step;
        for (int c = 0; c < 4; c++) if (chs[c]) i_trigger_source_select[6*c +: 6] = codes[c];
        i_cnt_load = chs;
        i_cnt_value = cnt[15:0];
        @(posedge i_clk);
        #1 i_cnt_load = 4'h0;
        for (int c = 0; c < 4; c++) if (chs[c]) i_irq_src[codes[c]] = 1'b1;
        wait_words(n);
        #1 i_irq_src = '0;
        for (int i = 0; i < n; i++) check(got[i], exp[2*i +: 2]);
        check(dones - d0, n / cnt);
    endtask : run
    initial begin
        void'($urandom(32'h00C8CFE1));
        repeat (5) @(posedge i_clk);
        #1 i_rst = 1'b0;
        for (k = 0; k < 4; k++) run(4'h1 << k, 4'h0, 1, {30'h0, k[1:0]}, 1);
        run(4'b1001, 4'h0, 3, order(4'b1001, 3), 6);
        run(4'b1101, 4'h0, 2, order(4'b1101, 2), 6);
        run(4'b0011, 4'b0011, 1, order(4'b0011, 1), 2);
        // Channel 3 chained on channel 0's terminal count
        i_trigger_source_select[23:18] = `DTSM_SRC_DONE0;
        i_cnt_load = 4'h8;
        i_cnt_value = 16'h0001;
        @(posedge i_clk);
        #1 i_cnt_load = 4'h0;
        run(4'b0001, 4'h0, 1, 32'h0000000C, 2);
        for (k = 0; k < 3; k++) begin
            m = $urandom_range(1, 15);
            q = $urandom_range(1, 3);
            run(m[3:0], 4'h0, q, order(m[3:0], q), q * $countones(m[3:0]));
        end
        // Single-step with a steady level gives one unit per rising request
        got.delete();
        i_step_mode = 4'h2;
        i_cnt_load = 4'h2;
        i_cnt_value = 16'h0002;
        @(posedge i_clk);
        #1 i_cnt_load = 4'h0;
        i_irq_src[codes[1]] = 1'b1;
        repeat (40) @(posedge i_clk);
        #1 check(got.size(), 1);
        i_irq_src = '0;
        repeat (3) @(posedge i_clk);
        #1 i_irq_src[codes[1]] = 1'b1;
        wait_words(2);
        #1 check(o_active, 4'h0);
        // Stalled drain: eight words fill the buffer, then the run stops until drained
        hold = 1'b1;
        i_step_mode = 4'h0;
        got.delete();
        m = units;
        i_cnt_load = 4'h4;
        i_cnt_value = 16'h000A;
        @(posedge i_clk);
        #1 i_cnt_load = 4'h0;
        i_irq_src[codes[2]] = 1'b1;
        repeat (150) @(posedge i_clk);
        #1 check(units - m, 8);
        hold = 1'b0;
        wait_words(10);
        check(got[9], 2'h2);
        wrap_up();
    end
endmodule : testbench
